// file: mul_unit_pkg.sv
// Constants and types for the multiply instruction unit
// Behaviour
// - The halfword constant multiply takes the low halfword of the first source times the 16-bit constant and writes one word to the second register.
// - The upper 16 bits of the first source have no effect on the halfword constant product.
// - Neither multiply writes the first source register in its register form.
// - The unsigned word multiply in register form writes the high product word to the third register and the low word to the second register.
// - The constant form zero-extends the 9-bit constant to 32 bits and splits the product the same way.
// - The 9-bit constant takes its low 5 bits from the five-bit field and its high 4 bits from the four-bit field.
// - When second and third register are the same, the upper product word is what remains in it.
package mul_unit_pkg;
  localparam int WORD_W = 32;
  localparam int HALF_W = 16;
  localparam int REG_IDX_W = 5;
  localparam int LOW_FIELD_W = 5;
  localparam int HIGH_FIELD_W = 4;
  localparam int SHORT_W = LOW_FIELD_W + HIGH_FIELD_W;
  localparam int FLAG_W = 5;
  localparam logic [REG_IDX_W-1:0] ZERO_GPR = 5'h00;

  typedef enum logic [2:0] {
    OP_NONE = 3'h1,
    OP_HALF_CONST = 3'h2,
    OP_WORD_UNSIGNED = 3'h4
  } mul_op_t;

  typedef struct packed {
    mul_op_t op;
    logic use_short_const;
    logic [REG_IDX_W-1:0] first_idx;
    logic [REG_IDX_W-1:0] second_idx;
    logic [REG_IDX_W-1:0] third_idx;
    logic [WORD_W-1:0] first_source_gpr;
    logic [WORD_W-1:0] second_gpr;
    logic [HALF_W-1:0] second_halfword;
    logic [LOW_FIELD_W-1:0] short_low_field;
    logic [HIGH_FIELD_W-1:0] short_high_field;
  } mul_req_t;

  typedef struct packed {
    logic wr_a;
    logic [REG_IDX_W-1:0] idx_a;
    logic [WORD_W-1:0] data_a;
    logic wr_b;
    logic [REG_IDX_W-1:0] idx_b;
    logic [WORD_W-1:0] data_b;
    logic flags_write;
  } mul_wb_t;
endpackage : mul_unit_pkg

// file: multiply_instruction_unit.sv
// Multiply datapath: halfword constant product and unsigned word product
module multiply_instruction_unit (
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_n_in,
  // Decoded request, valid for one cycle
  input wire logic req_valid_in,
  input wire mul_unit_pkg::mul_req_t req_in,
  // Status flags held by the core
  input wire logic [mul_unit_pkg::FLAG_W-1:0] flags_in,
  // Register write-back, one cycle after the request
  output mul_unit_pkg::mul_wb_t wb_out,
  output logic wb_valid_out,
  output logic [mul_unit_pkg::FLAG_W-1:0] flags_out
);
  import mul_unit_pkg::*;

  function automatic logic [WORD_W-1:0] short_const(input logic [LOW_FIELD_W-1:0] lo,
                                                    input logic [HIGH_FIELD_W-1:0] hi);
    short_const = {{(WORD_W-SHORT_W){1'b0}}, hi, lo};
  endfunction : short_const

  function automatic logic [WORD_W-1:0] half_product(input logic [HALF_W-1:0] lo_half,
                                                     input logic [HALF_W-1:0] factor);
    half_product = {{HALF_W{1'b0}}, lo_half} * {{HALF_W{1'b0}}, factor};
  endfunction : half_product

  mul_wb_t wb, next_wb;
  logic wb_valid, next_wb_valid;
  logic [FLAG_W-1:0] flags, next_flags;
  logic [2*WORD_W-1:0] wide_product;
  logic [WORD_W-1:0] multiplier;

  always_comb begin
    multiplier = req_in.use_short_const ?
      short_const(req_in.short_low_field, req_in.short_high_field) : req_in.first_source_gpr;
    wide_product = {{WORD_W{1'b0}}, req_in.second_gpr} * {{WORD_W{1'b0}}, multiplier};
    next_wb = '0;
    next_wb_valid = 1'b0;
    next_flags = flags_in;
    if (req_valid_in) begin
      case (req_in.op)
        OP_HALF_CONST: begin
          // Constant comes from the second halfword of the instruction
          next_wb.wr_a = 1'b1;
          next_wb.idx_a = req_in.second_idx;
          next_wb.data_a = half_product(req_in.first_source_gpr[HALF_W-1:0],
                                        req_in.second_halfword);
          next_wb_valid = 1'b1;
        end
        OP_WORD_UNSIGNED: begin
          // Port a takes the low word, port b the high word; port a is dropped when both share an index
          next_wb.wr_a = 1'b1;
          next_wb.idx_a = req_in.second_idx;
          next_wb.data_a = wide_product[WORD_W-1:0];
          next_wb.wr_b = 1'b1;
          next_wb.idx_b = req_in.third_idx;
          next_wb.data_b = wide_product[2*WORD_W-1:WORD_W];
          if (req_in.second_idx == req_in.third_idx) begin
            next_wb.wr_a = 1'b0;
          end
          next_wb_valid = 1'b1;
        end
        default: begin
          next_wb_valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wb <= '0;
      wb_valid <= 1'b0;
      flags <= '0;
    end else begin
      wb <= next_wb;
      wb_valid <= next_wb_valid;
      flags <= next_flags;
    end
  end

  assign wb_out = wb;
  assign wb_valid_out = wb_valid;
  assign flags_out = flags;

  property p_half_product;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_HALF_CONST) |=> wb.wr_a &&
      wb.data_a == {{HALF_W{1'b0}}, $past(req_in.first_source_gpr[HALF_W-1:0])} *
                   {{HALF_W{1'b0}}, $past(req_in.second_halfword)};
  endproperty
  a_half_product: assert property (p_half_product) else $error("halfword product wrong");

  property p_upper_ignored;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_HALF_CONST) |=> wb.data_a[WORD_W-1:HALF_W] ==
      HALF_W'(({{HALF_W{1'b0}}, $past(req_in.first_source_gpr[HALF_W-1:0])} *
               {{HALF_W{1'b0}}, $past(req_in.second_halfword)}) >> HALF_W);
  endproperty
  a_upper_ignored: assert property (p_upper_ignored) else $error("upper bits leaked");

  property p_source_kept;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_HALF_CONST) |=> !wb.wr_b &&
      wb.idx_a == $past(req_in.second_idx);
  endproperty
  a_source_kept: assert property (p_source_kept) else $error("source register written");

  property p_word_split;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_WORD_UNSIGNED && !req_in.use_short_const) |=>
      {wb.data_b, wb.data_a} == {{WORD_W{1'b0}}, $past(req_in.second_gpr)} *
                                {{WORD_W{1'b0}}, $past(req_in.first_source_gpr)};
  endproperty
  a_word_split: assert property (p_word_split) else $error("word product split wrong");

  property p_short_form;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_WORD_UNSIGNED && req_in.use_short_const) |=>
      {wb.data_b, wb.data_a} == {{WORD_W{1'b0}}, $past(req_in.second_gpr)} *
        {{(2*WORD_W-SHORT_W){1'b0}}, $past(req_in.short_high_field),
         $past(req_in.short_low_field)};
  endproperty
  a_short_form: assert property (p_short_form) else $error("short constant product wrong");

  property p_field_order;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.use_short_const) |->
      multiplier[LOW_FIELD_W-1:0] == req_in.short_low_field &&
      multiplier[SHORT_W-1:LOW_FIELD_W] == req_in.short_high_field &&
      multiplier[WORD_W-1:SHORT_W] == '0;
  endproperty
  a_field_order: assert property (p_field_order) else $error("short constant fields wrong");

  property p_same_dest;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_WORD_UNSIGNED && req_in.second_idx == req_in.third_idx)
      |=> wb.wr_b && !wb.wr_a;
  endproperty
  a_same_dest: assert property (p_same_dest) else $error("shared register not left high");

  property p_flags_kept;
    @(posedge clk_in) disable iff (!reset_n_in)
    req_valid_in |=> flags == $past(flags_in) && !wb.flags_write;
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("status flags changed");

  // Request shapes shared by the checks below
  sequence s_half_req;
    req_valid_in && req_in.op == OP_HALF_CONST;
  endsequence

  sequence s_word_req;
    req_valid_in && req_in.op == OP_WORD_UNSIGNED;
  endsequence

  sequence s_other_req;
    req_valid_in && req_in.op != OP_HALF_CONST && req_in.op != OP_WORD_UNSIGNED;
  endsequence

  sequence s_wb_pulse;
    wb_valid && (wb.wr_a || wb.wr_b);
  endsequence

  property p_half_valid;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_half_req |=> s_wb_pulse;
  endproperty
  a_half_valid: assert property (p_half_valid) else $error("halfword write-back missing");

  property p_word_high_port;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_word_req |=> s_wb_pulse ##0 (wb.wr_b && wb.idx_b == $past(req_in.third_idx));
  endproperty
  a_word_high_port: assert property (p_word_high_port) else $error("high word port wrong");

  property p_word_low_port;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_WORD_UNSIGNED && req_in.second_idx != req_in.third_idx)
      |=> wb.wr_a && wb.idx_a == $past(req_in.second_idx);
  endproperty
  a_word_low_port: assert property (p_word_low_port) else $error("low word port wrong");

  property p_short_range;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_WORD_UNSIGNED && req_in.use_short_const)
      |=> wb.data_b[WORD_W-1:SHORT_W] == '0;
  endproperty
  a_short_range: assert property (p_short_range) else $error("short constant not zero-extended");

  property p_same_high;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_WORD_UNSIGNED && req_in.second_idx == req_in.third_idx)
      |=> wb.idx_b == $past(req_in.second_idx);
  endproperty
  a_same_high: assert property (p_same_high) else $error("shared register index wrong");

  property p_source_untouched;
    @(posedge clk_in) disable iff (!reset_n_in)
    (req_valid_in && req_in.op == OP_WORD_UNSIGNED && !req_in.use_short_const &&
     req_in.first_idx != req_in.second_idx && req_in.first_idx != req_in.third_idx)
      |=> (!wb.wr_a || wb.idx_a != $past(req_in.first_idx)) && wb.idx_b != $past(req_in.first_idx);
  endproperty
  a_source_untouched: assert property (p_source_untouched) else $error("word source written");

  // Contract checks: refused codes, idle cycles and reset
  property p_refused;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_other_req |=> !wb_valid && !wb.wr_a && !wb.wr_b;
  endproperty
  a_refused: assert property (p_refused) else $error("refused code wrote back");

  property p_idle;
    @(posedge clk_in) disable iff (!reset_n_in)
    !req_valid_in |=> !wb_valid && wb == '0;
  endproperty
  a_idle: assert property (p_idle) else $error("write-back without request");

  property p_reset_clear;
    @(posedge clk_in)
    (!reset_n_in && $past(!reset_n_in)) |-> wb == '0 && !wb_valid && flags == '0;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared in reset");
endmodule : multiply_instruction_unit

// file: regfile_model.sv
// Register file model that applies multiply write-backs
module regfile_model (
  // Clock
  input wire logic clk_in,
  // Write-back from the unit
  input wire logic wb_valid_in,
  input wire mul_unit_pkg::mul_wb_t wb_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import mul_unit_pkg::*;
  logic [WORD_W-1:0] gpr [32];
  initial for (int i = 0; i < 32; i++) gpr[i] = 32'h9E3779B9 * i;
  // Port a first, so port b wins on a shared index
  always @(posedge clk_in) begin
    if (wb_valid_in && wb_in.wr_a && wb_in.idx_a != ZERO_GPR) gpr[wb_in.idx_a] <= wb_in.data_a;
    if (wb_valid_in && wb_in.wr_b && wb_in.idx_b != ZERO_GPR) gpr[wb_in.idx_b] <= wb_in.data_b;
  end
endmodule : regfile_model

// file: tb.sv
// Self-checking bench for the multiply instruction unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mul_unit_pkg::*;
  logic clk_in = 0;
  logic reset_n_in = 0;
  logic req_valid_in = 0;
  mul_req_t req_in = '0;
  logic [FLAG_W-1:0] flags_in = '0;
  mul_wb_t wb_out;
  logic wb_valid_out;
  logic [FLAG_W-1:0] flags_out;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 67660;
  mul_wb_t exp_q[$];
  multiply_instruction_unit dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .req_valid_in(req_valid_in), .req_in(req_in), .flags_in(flags_in),
    .wb_out(wb_out), .wb_valid_out(wb_valid_out), .flags_out(flags_out));
  regfile_model rf_u (.clk_in(clk_in), .wb_valid_in(wb_valid_out), .wb_in(wb_out));
  initial forever #4 clk_in = ~clk_in;
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task chk_wb(input logic valid_exp);
    mul_wb_t e;
    e = exp_q.pop_front();
    chk(wb_valid_out, valid_exp);
    chk({wb_out.wr_a, wb_out.wr_b, wb_out.flags_write}, {e.wr_a, e.wr_b, 1'b0});
    if (e.wr_a) chk({wb_out.idx_a, wb_out.data_a}, {e.idx_a, e.data_a});
    if (e.wr_b) chk({wb_out.idx_b, wb_out.data_b}, {e.idx_b, e.data_b});
    if (!valid_exp) chk(wb_out === e, 1'b1);
  endtask : chk_wb
  task chk_flags(input logic [FLAG_W-1:0] f_exp);
    chk(flags_out, f_exp);
  endtask : chk_flags
  task chk_reg(input logic [REG_IDX_W-1:0] idx, input logic [WORD_W-1:0] v_exp);
    chk(rf_u.gpr[idx], v_exp);
  endtask : chk_reg
  task conclude;
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task run(input int n);
    mul_req_t r;
    logic [127:0] rnd;
    logic [63:0] p;
    logic [31:0] b;
    logic [FLAG_W-1:0] f;
    int k;
    mul_wb_t e;
    rnd = {$random(seed), $random(seed), $random(seed), $random(seed)};
    r = mul_req_t'(rnd[$bits(mul_req_t)-1:0]);
    k = n % 4;
    r.op = (k == 0) ? ((n % 8 == 4) ? mul_op_t'(3'h7) : OP_NONE)
         : (k == 1) ? OP_HALF_CONST : OP_WORD_UNSIGNED;
    r.use_short_const = (k == 3);
    if (n % 8 == 6) r.third_idx = r.second_idx;
    if (k == 1 && r.second_idx == ZERO_GPR) r.second_idx = 5'h01;
    if (k == 2 && r.first_idx == r.third_idx && r.first_idx != r.second_idx
        && r.first_idx != ZERO_GPR) r.third_idx = r.second_idx;
    r.first_source_gpr = rf_u.gpr[r.first_idx];
    r.second_gpr = rf_u.gpr[r.second_idx];
    b = r.use_short_const ? {23'h0, r.short_high_field, r.short_low_field} : r.first_source_gpr;
    p = (k == 1) ? r.first_source_gpr[15:0] * r.second_halfword : r.second_gpr * b;
    f = FLAG_W'($random(seed));
    e = '0;
    if (k != 0) begin
      e.wr_a = (k == 1) || (r.second_idx != r.third_idx);
      e.idx_a = r.second_idx;
      e.data_a = p[31:0];
      e.wr_b = (k > 1);
      e.idx_b = (k > 1) ? r.third_idx : ZERO_GPR;
      e.data_b = (k > 1) ? p[63:32] : 32'h00000000;
    end
    exp_q.push_back(e);
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_in <= r;
    flags_in <= f;
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    #1;
    chk_wb(k != 0);
    chk_flags(f);
    @(posedge clk_in);
    #1;
    chk(wb_valid_out, 1'b0);
    chk_flags(f);
    if (k > 1 && r.third_idx != ZERO_GPR) chk_reg(r.third_idx, p[63:32]);
    if (e.wr_a && r.second_idx != ZERO_GPR) chk_reg(r.second_idx, p[31:0]);
    if (k > 0 && r.first_idx != r.second_idx && (k == 1 || r.first_idx != r.third_idx))
      chk_reg(r.first_idx, r.first_source_gpr);
  endtask : run
  initial begin
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int n = 0; n < 200; n++) run(n);
    conclude();
  end
  initial begin
    #20000;
    err_total++;
    conclude();
  end
endmodule : tb
